// [verilog/csic_params.svh]
// constants of the charger state and indicator control block
// Behaviour
// RULE_01 - fast charge limit hours equal nF over 73
// RULE_02 - trickle limit about one ninth of fast
// RULE_03 - timeout stops charge, flash charge lamp
// RULE_04 - zero timer capacitor disables the charge timer
// RULE_05 - self-test and store supply before charging
// RULE_06 - reduce current when supply droop hits limit
// RULE_07 - two open-drain lamps, lit when low
// RULE_08 - charging: charge lamp lit, done dark
// RULE_09 - complete: charge lamp dark, done lit
// RULE_10 - faults: done dark, charge lamp 1 Hz
// RULE_11 - no battery: done lit, charge lamp blinks
// RULE_12 - no battery, sense high: pure boost
// RULE_13 - die hot folds current back, hotter off
// RULE_14 - sense outside window suspends charging
// RULE_15 - sense tied to supply: pure boost
// RULE_16 - sense grounded stops charging
// RULE_17 - no termination while current is reduced
// RULE_18 - filtered recharge after falling by margin
// RULE_19 - upper sense threshold 75 percent supply
// RULE_20 - lower sense threshold 30 percent supply
// RULE_21 - other states: both lamps dark
// RULE_22 - flash from counter, equal lit and dark
`ifndef CSIC_PARAMS_SVH
`define CSIC_PARAMS_SVH
`define CSIC_CLK_HZ         64'd25000000
`define CSIC_CAP_PER_HOUR   73
`define CSIC_TRICKLE_DIV    9
`define CSIC_HOUR_S         64'd3600
`define CSIC_TICK_CYC       ((`CSIC_CLK_HZ*`CSIC_HOUR_S)/(`CSIC_CAP_PER_HOUR*`CSIC_TRICKLE_DIV))
`define CSIC_FLASH_HZ       1
`define CSIC_FLASH_HALF_CYC (`CSIC_CLK_HZ/(2*`CSIC_FLASH_HZ))
`define CSIC_NOBAT_HZ       2
`define CSIC_NOBAT_HALF_CYC (`CSIC_CLK_HZ/(2*`CSIC_NOBAT_HZ))
`define CSIC_FILT_MS        30
`define CSIC_FILT_CYC       ((`CSIC_CLK_HZ*`CSIC_FILT_MS)/1000)
`define CSIC_SELFTEST_CYC   16
`define CSIC_NTC_HI_PCT     75
`define CSIC_NTC_LO_PCT     30
`define CSIC_NTC_HI_CODE    ((`CSIC_NTC_HI_PCT*255)/100)
`define CSIC_NTC_LO_CODE    ((`CSIC_NTC_LO_PCT*255)/100)
`define CSIC_NTC_TIED_HI    8'hFA
`define CSIC_NTC_GROUNDED   8'h05
`define CSIC_OFF_TIMER      8'h00
`define CSIC_OFF_DROOP      8'h04
`define CSIC_OFF_STATUS     8'h08
`define CSIC_OFF_ELAPSED    8'h0C
`define CSIC_RST_TIMER_NF   16'h014A
`define CSIC_RST_DROOP      8'h10
`define CSIC_RESP_OKAY      2'h0
`define CSIC_RESP_SLVERR    2'h2
`endif

// [verilog/csic_pkg.sv]
// types of the charger state and indicator control block
package csic_pkg;
  typedef enum logic [3:0] {
    ST_OFF, ST_SELFTEST, ST_CHARGE, ST_DONE, ST_TIMEOUT,
    ST_SUSPEND, ST_NOBAT, ST_BOOST, ST_STOP
  } csic_state_t;
endpackage : csic_pkg

// [verilog/csic_top.sv]
// charger state machine, lamp driver and axi4-lite register slave
`include "csic_params.svh"
module csic_top #(
  parameter int unsigned TICK_CYC       = 32'(`CSIC_TICK_CYC),
  parameter int unsigned FLASH_HALF_CYC = 32'(`CSIC_FLASH_HALF_CYC),
  parameter int unsigned NOBAT_HALF_CYC = 32'(`CSIC_NOBAT_HALF_CYC),
  parameter int unsigned FILT_CYC       = 32'(`CSIC_FILT_CYC)
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // analog front-end conditions
  input  wire logic        supply_present,
  input  wire logic        supply_ovp,
  input  wire logic [7:0]  supply_level,
  input  wire logic [7:0]  batt_temp_sense,
  input  wire logic        batt_present,
  input  wire logic        batt_short,
  input  wire logic        batt_below_trickle,
  input  wire logic        batt_term_cmp,
  input  wire logic        batt_recharge_cmp,
  input  wire logic        die_over_fold,
  input  wire logic        die_over_off,
  // power stage control
  output logic             charge_en,
  output logic             boost_en,
  output logic             current_reduce,
  output logic             trickle_mode,
  // open-drain lamps, enable low while pulling
  output logic             charge_lamp_out_o,
  output logic             charge_lamp_out_oe_n,
  output logic             done_lamp_out_o,
  output logic             done_lamp_out_oe_n
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [31:0] sat_inc(input logic [31:0] v);
    sat_inc = (v == 32'hFFFFFFFF) ? v : v + 32'h1;
  endfunction : sat_inc

  ////////////////////////////////////////////////////////////////////////////
  // register bus

  logic        awready_q, awready_d, wready_q, wready_d;
  logic        bvalid_q, bvalid_d, arready_q, arready_d;
  logic        rvalid_q, rvalid_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [15:0] timer_nf_q, timer_nf_d;
  logic [7:0]  droop_lim_q, droop_lim_d;
  logic        wr_go, rd_go;

  csic_pkg::csic_state_t state_q, state_d;
  logic [31:0] elapsed_q, elapsed_d;
  logic [7:0]  stored_q, stored_d;
  logic        reduce_q, reduce_d;

  // write taken only with both address and data present
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_q && !awready_q;
  assign rd_go = s_axi_arvalid && !rvalid_q && !arready_q;

  always_comb begin
    awready_d   = wr_go;
    wready_d    = wr_go;
    bvalid_d    = bvalid_q;
    bresp_d     = bresp_q;
    arready_d   = rd_go;
    rvalid_d    = rvalid_q;
    rresp_d     = rresp_q;
    rdata_d     = rdata_q;
    timer_nf_d  = timer_nf_q;
    droop_lim_d = droop_lim_q;
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (awready_q) bvalid_d = 1'b1; // answer only after aw/w handshake
    if (wr_go) begin
      bresp_d  = `CSIC_RESP_OKAY;
      case (s_axi_awaddr)
        `CSIC_OFF_TIMER: begin
          if (s_axi_wstrb[0]) timer_nf_d[7:0]  = s_axi_wdata[7:0];
          if (s_axi_wstrb[1]) timer_nf_d[15:8] = s_axi_wdata[15:8];
        end
        `CSIC_OFF_DROOP: begin
          if (s_axi_wstrb[0]) droop_lim_d = s_axi_wdata[7:0];
        end
        `CSIC_OFF_STATUS, `CSIC_OFF_ELAPSED: begin
        end
        default: bresp_d = `CSIC_RESP_SLVERR;
      endcase
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (arready_q) rvalid_d = 1'b1; // data only after ar handshake
    if (rd_go) begin
      rresp_d  = `CSIC_RESP_OKAY;
      case (s_axi_araddr)
        `CSIC_OFF_TIMER:   rdata_d = {16'h0000, timer_nf_q};
        `CSIC_OFF_DROOP:   rdata_d = {24'h000000, droop_lim_q};
        `CSIC_OFF_STATUS:  rdata_d = {15'h0000, reduce_q, stored_q,
                                      4'h0, 4'(state_q)};
        `CSIC_OFF_ELAPSED: rdata_d = elapsed_q;
        default: begin
          rdata_d = 32'h00000000;
          rresp_d = `CSIC_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q   <= 1'b0;
      wready_q    <= 1'b0;
      bvalid_q    <= 1'b0;
      bresp_q     <= `CSIC_RESP_OKAY;
      arready_q   <= 1'b0;
      rvalid_q    <= 1'b0;
      rresp_q     <= `CSIC_RESP_OKAY;
      rdata_q     <= 32'h00000000;
      timer_nf_q  <= `CSIC_RST_TIMER_NF;
      droop_lim_q <= `CSIC_RST_DROOP;
    end else begin
      awready_q   <= awready_d;
      wready_q    <= wready_d;
      bvalid_q    <= bvalid_d;
      bresp_q     <= bresp_d;
      arready_q   <= arready_d;
      rvalid_q    <= rvalid_d;
      rresp_q     <= rresp_d;
      rdata_q     <= rdata_d;
      timer_nf_q  <= timer_nf_d;
      droop_lim_q <= droop_lim_d;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // charge state machine

  logic [31:0] tick_q, tick_d, filt_q, filt_d, flash_q, flash_d;
  logic [31:0] blink_q, blink_d;
  logic        phase_q, phase_d, flash_on_q, flash_on_d;
  logic        blink_on_q, blink_on_d;
  logic        ntc_high, ntc_gnd, ntc_ok, droop;
  logic [31:0] limit;
  logic        chg_en_q, chg_en_d, bst_en_q, bst_en_d, trk_q, trk_d;
  logic        chg_lit_q, chg_lit_d, done_lit_q, done_lit_d;
  csic_pkg::csic_state_t cls;

  // window of the temperature divider as a share of the supply
  assign ntc_high = batt_temp_sense >= `CSIC_NTC_TIED_HI;
  assign ntc_gnd  = batt_temp_sense <= `CSIC_NTC_GROUNDED;
  assign ntc_ok   = batt_temp_sense > 8'(`CSIC_NTC_LO_CODE) && // [RULE_20]
                    batt_temp_sense < 8'(`CSIC_NTC_HI_CODE);   // [RULE_19]
  // droop measured against the level held at self-test end
  assign droop    = supply_level < stored_q &&
                    (stored_q - supply_level) >= droop_lim_q; // [RULE_06]
  // tick is 1/657 hour: fast limit nF*9 ticks, trickle nF ticks
  assign limit    = phase_q ? {16'h0000, timer_nf_q}               // [RULE_02]
                            : 32'(timer_nf_q) * 32'(`CSIC_TRICKLE_DIV); // [RULE_01]

  always_comb begin
    if (ntc_gnd) begin
      cls = csic_pkg::ST_STOP;                                 // [RULE_16]
    end else if (ntc_high) begin
      cls = csic_pkg::ST_BOOST;                          // [RULE_12] [RULE_15]
    end else if (supply_ovp || batt_short || !ntc_ok) begin
      cls = csic_pkg::ST_SUSPEND;                              // [RULE_14]
    end else if (!batt_present) begin
      cls = csic_pkg::ST_NOBAT;
    end else begin
      cls = csic_pkg::ST_CHARGE;
    end
  end

  always_comb begin
    state_d   = state_q;
    elapsed_d = elapsed_q;
    tick_d    = tick_q;
    filt_d    = 32'h0;
    stored_d  = stored_q;
    phase_d   = batt_below_trickle;
    reduce_d  = 1'b0;
    case (state_q)
      csic_pkg::ST_OFF: begin
        elapsed_d = 32'h0;
        state_d   = csic_pkg::ST_SELFTEST;
      end
      csic_pkg::ST_SELFTEST: begin
        elapsed_d = sat_inc(elapsed_q);
        if (elapsed_q == 32'(`CSIC_SELFTEST_CYC - 1)) begin
          stored_d  = supply_level;                            // [RULE_05]
          elapsed_d = 32'h0;
          tick_d    = 32'h0;
          state_d   = cls;
        end
      end
      csic_pkg::ST_CHARGE: begin
        reduce_d = droop || die_over_fold;              // [RULE_06] [RULE_13]
        tick_d   = (tick_q == TICK_CYC - 1) ? 32'h0 : tick_q + 32'h1;
        if (tick_q == TICK_CYC - 1) elapsed_d = sat_inc(elapsed_q);
        if (phase_q != batt_below_trickle) elapsed_d = 32'h0;
        // termination filter held off while current is cut back
        if (batt_term_cmp && !reduce_q) begin                  // [RULE_17]
          filt_d = sat_inc(filt_q);
        end
        if (cls != csic_pkg::ST_CHARGE) begin
          state_d = cls;
        end else if (timer_nf_q != 16'h0000 &&                 // [RULE_04]
                     elapsed_q >= limit) begin
          state_d = csic_pkg::ST_TIMEOUT;                      // [RULE_03]
        end else if (batt_term_cmp && !reduce_q && filt_q >= FILT_CYC-1) begin
          state_d = csic_pkg::ST_DONE;
        end
      end
      csic_pkg::ST_DONE: begin
        if (batt_recharge_cmp) filt_d = sat_inc(filt_q);       // [RULE_18]
        if (cls != csic_pkg::ST_CHARGE) begin
          state_d = cls;
        end else if (batt_recharge_cmp && filt_q >= FILT_CYC - 1) begin
          state_d   = csic_pkg::ST_CHARGE;                     // [RULE_18]
          elapsed_d = 32'h0;
          tick_d    = 32'h0;
        end
      end
      csic_pkg::ST_TIMEOUT: begin
        state_d = csic_pkg::ST_TIMEOUT;                        // [RULE_03]
      end
      csic_pkg::ST_SUSPEND: begin
        // timer keeps its count across a suspension
        if (cls != csic_pkg::ST_SUSPEND) state_d = cls;        // [RULE_14]
      end
      csic_pkg::ST_NOBAT, csic_pkg::ST_BOOST, csic_pkg::ST_STOP: begin
        if (cls != state_q) begin
          state_d   = cls;
          elapsed_d = 32'h0;
          tick_d    = 32'h0;
        end
      end
      default: state_d = csic_pkg::ST_OFF;
    endcase
    if (!supply_present) begin
      state_d = csic_pkg::ST_OFF;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flash generators and lamp decode

  always_comb begin
    flash_d    = (flash_q == FLASH_HALF_CYC - 1) ? 32'h0 : flash_q + 32'h1;
    flash_on_d = (flash_q == FLASH_HALF_CYC - 1) ? !flash_on_q
                                                 : flash_on_q; // [RULE_22]
    blink_d    = (blink_q == NOBAT_HALF_CYC - 1) ? 32'h0 : blink_q + 32'h1;
    blink_on_d = (blink_q == NOBAT_HALF_CYC - 1) ? !blink_on_q
                                                 : blink_on_q; // [RULE_22]
    chg_lit_d  = 1'b0;                                         // [RULE_21]
    done_lit_d = 1'b0;                                         // [RULE_21]
    chg_en_d   = 1'b0;
    bst_en_d   = 1'b0;
    trk_d      = 1'b0;
    case (state_d)
      csic_pkg::ST_CHARGE: begin
        chg_lit_d = 1'b1;                                      // [RULE_08]
        chg_en_d  = 1'b1;
        bst_en_d  = 1'b1;
        trk_d     = batt_below_trickle;
      end
      csic_pkg::ST_DONE: done_lit_d = 1'b1;                    // [RULE_09]
      csic_pkg::ST_TIMEOUT, csic_pkg::ST_SUSPEND: begin
        chg_lit_d = flash_on_d;                                // [RULE_10]
      end
      csic_pkg::ST_NOBAT: begin
        chg_lit_d  = blink_on_d;                               // [RULE_11]
        done_lit_d = 1'b1;
      end
      csic_pkg::ST_BOOST: begin
        done_lit_d = 1'b1;                                     // [RULE_12]
        bst_en_d   = 1'b1;                                     // [RULE_15]
      end
      default: begin
      end
    endcase
    // die shutdown overrides the charge and boost enable requests
    if (die_over_off) begin                                    // [RULE_13]
      chg_en_d = 1'b0;
      bst_en_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q    <= csic_pkg::ST_OFF;
      elapsed_q  <= 32'h0;
      tick_q     <= 32'h0;
      filt_q     <= 32'h0;
      stored_q   <= 8'h00;
      phase_q    <= 1'b0;
      reduce_q   <= 1'b0;
      flash_q    <= 32'h0;
      flash_on_q <= 1'b0;
      blink_q    <= 32'h0;
      blink_on_q <= 1'b0;
      chg_lit_q  <= 1'b0;
      done_lit_q <= 1'b0;
      chg_en_q   <= 1'b0;
      bst_en_q   <= 1'b0;
      trk_q      <= 1'b0;
    end else begin
      state_q    <= state_d;
      elapsed_q  <= elapsed_d;
      tick_q     <= tick_d;
      filt_q     <= filt_d;
      stored_q   <= stored_d;
      phase_q    <= phase_d;
      reduce_q   <= reduce_d;
      flash_q    <= flash_d;
      flash_on_q <= flash_on_d;
      blink_q    <= blink_d;
      blink_on_q <= blink_on_d;
      chg_lit_q  <= chg_lit_d;
      done_lit_q <= done_lit_d;
      chg_en_q   <= chg_en_d;
      bst_en_q   <= bst_en_d;
      trk_q      <= trk_d;
    end
  end

  // lamp lit means the pin is pulled low
  assign charge_lamp_out_o    = 1'b0;                          // [RULE_07]
  assign done_lamp_out_o      = 1'b0;                          // [RULE_07]
  assign charge_lamp_out_oe_n = !chg_lit_q;                    // [RULE_07]
  assign done_lamp_out_oe_n   = !done_lit_q;                   // [RULE_07]
  assign charge_en            = chg_en_q;
  assign boost_en             = bst_en_q;
  assign current_reduce       = reduce_q;
  assign trickle_mode         = trk_q;

endmodule : csic_top

// [verif/csic_chk_sva.sv]
// port checker for the charger state and lamp control block
module csic_chk (
  // clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // front-end conditions
  input wire logic [7:0] batt_temp_sense,
  input wire logic       batt_present,
  input wire logic       batt_term_cmp,
  input wire logic       die_over_off,
  // power and lamp outputs
  input wire logic       charge_en,
  input wire logic       boost_en,
  input wire logic       current_reduce,
  input wire logic       charge_lamp_out_o,
  input wire logic       charge_lamp_out_oe_n,
  input wire logic       done_lamp_out_o,
  input wire logic       done_lamp_out_oe_n
);
  logic cl;
  logic dl;
  logic norm;
  assign cl = !charge_lamp_out_oe_n;
  assign dl = !done_lamp_out_oe_n;
  // battery fitted and sense not tied high: only a real charge may end
  assign norm = batt_present && batt_temp_sense < 8'hFA;
  default clocking dck @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_reset_dark: assert property (
    $rose(aresetn) |-> !cl && !dl && !charge_en && !boost_en)
    else $error("outputs active after reset");
  a_selftest_dark: assert property (
    $rose(aresetn) |-> (!cl && !dl && !charge_en)[*8])
    else $error("charging before self-test ended");
  a_lamp_pull: assert property (
    !charge_lamp_out_o && !done_lamp_out_o)
    else $error("lamp pin driven high");
  a_charge_lamps: assert property (
    charge_en |-> cl && !dl)
    else $error("wrong lamps while charging");
  a_boost_lamps: assert property (
    boost_en && !charge_en |-> !cl && dl)
    else $error("wrong lamps in boost");
  a_die_off: assert property (
    die_over_off[*2] |-> !charge_en && !boost_en)
    else $error("power on while die too hot");
  a_grounded_stop: assert property (
    (batt_temp_sense <= 8'h05)[*4] |-> !charge_en && !boost_en)
    else $error("charging with sense grounded");
  a_window_hold: assert property (
    (batt_temp_sense > 8'h05 && (batt_temp_sense < 8'h4B
    || batt_temp_sense > 8'hC0 && batt_temp_sense < 8'hFA))[*4]
    |-> !charge_en) else $error("charging outside sense window");
  a_tied_boost: assert property (
    (batt_temp_sense >= 8'hFA)[*4] |-> !charge_en)
    else $error("charging with sense tied high");
  a_reduce_noterm: assert property (
    current_reduce && cl && !dl && norm |=> !(!cl && dl))
    else $error("charge ended while current reduced");
  a_term_needs_cmp: assert property (
    !batt_term_cmp && cl && !dl && norm |=> !(!cl && dl))
    else $error("charge ended without comparator");
  c_done: cover property (charge_en ##1 !charge_en && dl);
  c_boost: cover property (boost_en && !charge_en);
  c_hot: cover property (die_over_off && !charge_en);
endmodule : csic_chk
////////////////////////////////////////////////////////////////////////
bind csic_top csic_chk u_chk (.aclk, .aresetn, .batt_temp_sense,
  .batt_present, .batt_term_cmp, .die_over_off, .charge_en, .boost_en,
  .current_reduce, .charge_lamp_out_o, .charge_lamp_out_oe_n,
  .done_lamp_out_o, .done_lamp_out_oe_n);

// [verif/csic_batt_model.sv]
// battery and lamp model on the far side of the charger control
module csic_batt_model (
  // clock and charger drive
  input  wire logic        aclk,
  input  wire logic        charge_en,
  input  wire logic        chg_o,
  input  wire logic        chg_oe_n,
  input  wire logic        dn_o,
  input  wire logic        dn_oe_n,
  // capacity sets how soon the battery fills; drain is a load
  input  wire logic [15:0] fill_cyc,
  input  wire logic        drain,
  // comparators and lamp pin levels
  output logic             batt_term_cmp,
  output logic             batt_recharge_cmp,
  output logic             chg_lvl,
  output logic             dn_lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] fill_q = 16'h0;
  // lamps sit on pull-ups: a released pin reads high
  assign chg_lvl = chg_oe_n ? 1'b1 : chg_o;
  assign dn_lvl = dn_oe_n ? 1'b1 : dn_o;
  assign batt_term_cmp = charge_en && fill_q >= fill_cyc;
  assign batt_recharge_cmp = fill_q + 16'h4 <= fill_cyc;
  always @(posedge aclk) begin
    if (fill_q > fill_cyc) fill_q <= fill_cyc;
    else if (charge_en && fill_q < fill_cyc) fill_q <= fill_q + 16'h1;
    else if (drain && fill_q != 16'h0) fill_q <= fill_q - 16'h1;
  end
endmodule : csic_batt_model

// [verif/tb_top.sv]
// self-checking bench for the charger control block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, drain;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, supply_level, batt_temp_sense;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        supply_present, supply_ovp, batt_present, batt_short;
  logic        batt_below_trickle, batt_term_cmp, batt_recharge_cmp;
  logic        die_over_fold, die_over_off, charge_en, boost_en;
  logic        current_reduce, trickle_mode, chg_o, chg_oe_n, dn_o, dn_oe_n;
  logic        chg_lvl, dn_lvl;
  logic [15:0] fill_cyc;
  int          fail_count, cmp_count, cycles, h;
  csic_top #(.TICK_CYC(4), .FLASH_HALF_CYC(8), .NOBAT_HALF_CYC(4),
    .FILT_CYC(5)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .supply_present,
    .supply_ovp, .supply_level, .batt_temp_sense, .batt_present,
    .batt_short, .batt_below_trickle, .batt_term_cmp, .batt_recharge_cmp,
    .die_over_fold, .die_over_off, .charge_en, .boost_en, .current_reduce,
    .trickle_mode, .charge_lamp_out_o(chg_o), .charge_lamp_out_oe_n(chg_oe_n),
    .done_lamp_out_o(dn_o), .done_lamp_out_oe_n(dn_oe_n));
  csic_batt_model u_batt (.aclk, .charge_en, .chg_o, .chg_oe_n, .dn_o,
    .dn_oe_n, .fill_cyc, .drain, .batt_term_cmp, .batt_recharge_cmp,
    .chg_lvl, .dn_lvl);
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, e);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("Error at %0t ns: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, 32'h0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] m, e,
                    input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata & m, e);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask : rd
  // cycles between two charge lamp edges, 40 when it stays steady
  task automatic half_of();
    logic v;
    @(posedge aclk);
    v = chg_lvl;
    for (h = 0; h < 40 && chg_lvl === v; h++) @(posedge aclk);
    v = chg_lvl;
    for (h = 0; h < 40 && chg_lvl === v; h++) @(posedge aclk);
  endtask : half_of
  task automatic run_case(input logic [7:0] s, input logic p, o, sh,
                          input logic [3:0] st, input logic dl, cl,
                          input int eh);
    batt_temp_sense <= s;
    batt_present <= p;
    supply_ovp <= o;
    batt_short <= sh;
    repeat (30) @(posedge aclk);
    rd(8'h08, 32'hF, {28'h0, st}, 2'h0);
    chk({31'h0, dn_lvl}, {31'h0, dl});
    half_of();
    chk(32'(h), 32'(eh));
    if (eh == 40) chk({31'h0, chg_lvl}, {31'h0, cl});
  endtask : run_case
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // run should need about 1300 cycles
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      $display("Error at %0t ns: got %h expected %h", $time, cycles, 0);
      summarize();
    end
  end
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
    {s_axi_rready, aresetn, drain, supply_ovp, batt_short} = 5'h0;
    {batt_below_trickle, die_over_fold, die_over_off} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {supply_present, batt_present, s_axi_wstrb} = 6'h3F;
    {supply_level, batt_temp_sense, fill_cyc} = 32'h8080FFF0;
    {fail_count, cmp_count, cycles} = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h08, 32'hF, 32'h1, 2'h0);
    chk({30'h0, chg_lvl, dn_lvl}, 32'h3);
    repeat (20) @(posedge aclk);
    rd(8'h08, 32'hFF0F, 32'h8002, 2'h0);
    chk({30'h0, chg_lvl, dn_lvl}, 32'h1);
    rd(8'h00, 32'hFFFFFFFF, 32'h14A, 2'h0);
    rd(8'h04, 32'hFFFFFFFF, 32'h10, 2'h0);
    rd(8'h10, 32'hFFFFFFFF, 32'h0, 2'h2);
    wr(8'h08, 32'hFFFFFFFF);
    rd(8'h08, 32'hF, 32'h2, 2'h0);
    $display("test reset and registers done");
    supply_level <= 8'h71;
    repeat (5) @(posedge aclk);
    rd(8'h08, 32'h1000F, 32'h2, 2'h0);
    supply_level <= 8'h70;
    repeat (4) @(posedge aclk);
    fill_cyc <= 16'h8;
    rd(8'h08, 32'h1000F, 32'h10002, 2'h0);
    repeat (30) @(posedge aclk);
    rd(8'h08, 32'hF, 32'h2, 2'h0);
    supply_level <= 8'h80;
    repeat (15) @(posedge aclk);
    rd(8'h08, 32'h1000F, 32'h3, 2'h0);
    chk({30'h0, chg_lvl, dn_lvl}, 32'h2);
    wr(8'h00, 32'h2);
    drain <= 1'b1;
    for (int n = 0; n < 300 && chg_lvl !== 1'b0; n++) @(posedge aclk);
    drain <= 1'b0;
    fill_cyc <= 16'hFFF0;
    rd(8'h08, 32'hF, 32'h2, 2'h0);
    $display("test droop and termination done");
    repeat (55) @(posedge aclk);
    rd(8'h08, 32'hF, 32'h2, 2'h0);
    repeat (22) @(posedge aclk);
    rd(8'h08, 32'hF, 32'h4, 2'h0);
    chk({30'h0, charge_en, dn_lvl}, 32'h1);
    half_of();
    chk(32'(h), 32'h8);
    supply_present <= 1'b0;
    batt_below_trickle <= 1'b1;
    repeat (3) @(posedge aclk);
    supply_present <= 1'b1;
    repeat (45) @(posedge aclk);
    rd(8'h08, 32'hF, 32'h4, 2'h0);
    supply_present <= 1'b0;
    batt_below_trickle <= 1'b0;
    wr(8'h00, 32'h0);
    supply_present <= 1'b1;
    repeat (200) @(posedge aclk);
    rd(8'h08, 32'hF, 32'h2, 2'h0);
    $display("test charge timer done");
    die_over_fold <= 1'b1;
    batt_below_trickle <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(8'h08, 32'h1000F, 32'h10002, 2'h0);
    chk({30'h0, trickle_mode, current_reduce}, 32'h3);
    die_over_fold <= 1'b0;
    batt_below_trickle <= 1'b0;
    die_over_off <= 1'b1;
    repeat (3) @(posedge aclk);
    chk({30'h0, charge_en, boost_en}, 32'h0);
    die_over_off <= 1'b0;
    repeat (3) @(posedge aclk);
    chk({31'h0, charge_en}, 32'h1);
    $display("test die temperature done");
    run_case(8'h30, 1, 0, 0, 4'h5, 1, 1, 8);
    run_case(8'hD0, 1, 0, 0, 4'h5, 1, 1, 8);
    run_case(8'h80, 1, 1, 0, 4'h5, 1, 1, 8);
    run_case(8'h80, 1, 0, 1, 4'h5, 1, 1, 8);
    run_case(8'h02, 1, 0, 0, 4'h8, 1, 1, 40);
    run_case(8'hFF, 1, 0, 0, 4'h7, 0, 1, 40);
    run_case(8'h80, 0, 0, 0, 4'h6, 0, 1, 4);
    run_case(8'hFF, 0, 0, 0, 4'h7, 0, 1, 40);
    run_case(8'h4D, 1, 0, 0, 4'h2, 1, 0, 40);
    $display("test lamp table done");
    summarize();
  end
endmodule : tb_top
